// ---- shared/mfcc_defs.svh ----
/*
  Offsets, field positions, reset values and timing counts for the queue
  content configuration block. Assumes inclusion by bare name only.
*/
`ifndef MFCC_DEFS_SVH
`define MFCC_DEFS_SVH

// Register offsets
`define MFCC_OFF_SIDE_RATE 8'h44
`define MFCC_OFF_DECIM 8'h45
`define MFCC_OFF_THR_LOW 8'h46
`define MFCC_OFF_THR_HIGH 8'h47
`define MFCC_OFF_BEHAV 8'h48
`define MFCC_OFF_CONTENT 8'h49
`define MFCC_OFF_IRQ_STAT 8'h50
`define MFCC_OFF_IRQ_MASK 8'h51
`define MFCC_OFF_FILL_LOW 8'h56
`define MFCC_OFF_FILL_HIGH 8'h57

// Reset values
`define MFCC_RST_SIDE_RATE 8'h46
`define MFCC_RST_DECIM 8'h88
`define MFCC_RST_THR_LOW 8'h00
`define MFCC_RST_THR_HIGH 8'h02
`define MFCC_RST_BEHAV 8'h02
`define MFCC_RST_CONTENT 8'h10

// Field positions
`define MFCC_RATE_LSB 0
`define MFCC_OFFS_LSB 4
`define MFCC_GDEC_LSB 0
`define MFCC_GFILT_BIT 3
`define MFCC_ADEC_LSB 4
`define MFCC_AFILT_BIT 7
`define MFCC_STOP_BIT 0
`define MFCC_TIME_BIT 1
`define MFCC_TAG1_LSB 0
`define MFCC_TAG2_LSB 2
`define MFCC_HDR_BIT 4
`define MFCC_AUXEN_BIT 5
`define MFCC_ACCEN_BIT 6
`define MFCC_GYREN_BIT 7

// Side rate reserved codes
`define MFCC_RATE_RES_LO 4'h0
`define MFCC_RATE_RES_HI 4'hf

// Interrupt status bit positions
`define MFCC_IRQ_WTM 0
`define MFCC_IRQ_FULL 1
`define MFCC_IRQ_RATE_ERR 2

// Offset step in microseconds and its cycle count at 10 MHz
`define MFCC_STEP_US 2500
`define MFCC_CLK_MHZ 10
`define MFCC_STEP_CYC (`MFCC_STEP_US * `MFCC_CLK_MHZ)

`endif

// ---- shared/mfcc_pkg.sv ----
/*
  Types for the queue content configuration block.
  Assumes mfcc_defs.svh for numeric constants.
*/
package mfcc_pkg;
  // Decoded configuration presented to the datapath
  typedef struct packed {
    logic [3:0] side_rate;
    logic side_rate_ok;
    logic [3:0] side_offset;
    logic [2:0] gyro_decim;
    logic gyro_filtered;
    logic [2:0] accel_decim;
    logic accel_filtered;
    logic [12:0] threshold;
    logic stop_on_full;
    logic time_frame_en;
    logic [1:0] tag_select_first;
    logic [1:0] tag_select_second;
    logic header_en;
    logic aux_store_en;
    logic accel_store_en;
    logic gyro_store_en;
  } mfcc_cfg_type;

  // One accepted sample leaving the selection stage
  typedef struct packed {
    logic gyro_valid;
    logic accel_valid;
    logic aux_valid;
    logic gyro_filtered;
    logic accel_filtered;
    logic tag_first;
    logic tag_second;
    logic header_en;
  } mfcc_store_type;

  // Whole module state
  typedef struct packed {
    logic [7:0] side_rate_cfg;
    logic [7:0] decim_cfg;
    logic [7:0] thr_low;
    logic [7:0] thr_high;
    logic [7:0] behav_cfg;
    logic [7:0] content_cfg;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] rd_data;
    logic [6:0] gyro_cnt;
    logic [6:0] accel_cnt;
    logic [31:0] delay_cnt;
    logic [3:0] step_left;
    logic delay_busy;
    logic side_trig;
    logic wtm_seen;
    logic full_seen;
    logic [1:0] ev1_sync;
    logic [1:0] ev2_sync;
    logic ev1_prev;
    logic ev2_prev;
    mfcc_store_type store;
    logic time_frame;
  } mfcc_state_type;
endpackage

// ---- hw/mfcc_top.sv ----
/*
  Queue content configuration: registers for decimation, source select,
  watermark, stop-when-full, time frame, tags, header and store enables,
  plus the auxiliary rate check and readout offset delay.
  Assumes a single 10 MHz clock, a one-cycle strobe register port, sample
  strobes and the queue fill level from logic on the same clock, and the
  two event pins arriving asynchronously.
*/
// What this block does
// - Four-bit side rate, codes 0, f reserved
// - Delay side readout by 2.5 ms steps
// - Gyro decimation by two to field power
// - Accel decimation by two to field power
// - Source bit selects filtered or unfiltered samples
// - Watermark interrupt at low plus 256 times high
// - Stop-when-full blocks writes into full queue
// - Sensortime frame after last data frame
// - First tag source chosen by 2-bit code
// - Second tag source chosen the same way
// - Header bit selects headered or headerless frames
// - Aux data stored only when enabled
// - Accel data stored only when enabled
// - Gyro data stored only when enabled
`timescale 1ns/10ps
`include "mfcc_defs.svh"

module mfcc_top
  import mfcc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `MFCC_STEP_CYC,
  parameter int unsigned QUEUE_BYTES = 2048
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic gyro_sample,
  input wire logic accel_sample,
  input wire logic aux_sample,
  input wire logic side_tick,
  input wire logic accel_saturated,
  input wire logic gyro_saturated,
  input wire logic event_pin_first,
  input wire logic event_pin_second,
  input wire logic [12:0] queue_fill,
  input wire logic queue_drained,
  output mfcc_cfg_type cfg,
  output mfcc_store_type store,
  output logic store_valid,
  output logic side_trigger,
  output logic time_frame,
  output logic watermark,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // State
  mfcc_state_type st_q; // All registered state
  mfcc_state_type st_d; // Next state
  mfcc_cfg_type cfg_c; // Decoded configuration
  logic [12:0] thr_c; // Threshold in bytes
  logic full_c; // Queue has no room
  logic wtm_c; // Fill at or above threshold
  logic gyro_keep_c; // Gyro sample survives decimation
  logic accel_keep_c; // Accel sample survives decimation
  logic aux_keep_c; // Aux sample enabled
  logic edge1_c; // Rising edge of first pin
  logic edge2_c; // Rising edge of second pin

  // Group mask for a power-of-two decimation: counter low bits zero keeps
  function automatic logic decim_keep(input logic [6:0] cnt, input logic [2:0] pow);
    logic [6:0] mask;
    mask = 7'((8'h01 << pow) - 8'h01);
    decim_keep = ((cnt & mask) == 7'h00);
  endfunction

  // Next counter value for decimation, wrapping at the group size
  function automatic logic [6:0] decim_next(input logic [6:0] cnt, input logic [2:0] pow);
    logic [6:0] mask;
    mask = 7'((8'h01 << pow) - 8'h01);
    decim_next = (cnt + 7'h01) & mask;
  endfunction

  // Pick one tag source from a 2-bit code
  function automatic logic tag_pick(input logic [1:0] code, input logic edge_seen, input logic level,
                                    input logic acc_sat, input logic gyr_sat);
    unique case (code)
      2'h0: tag_pick = edge_seen;
      2'h1: tag_pick = level;
      2'h2: tag_pick = acc_sat;
      2'h3: tag_pick = gyr_sat;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration decode
  always_comb begin
    cfg_c = '0;
    cfg_c.side_rate = st_q.side_rate_cfg[`MFCC_RATE_LSB +: 4];
    cfg_c.side_rate_ok = (cfg_c.side_rate != `MFCC_RATE_RES_LO) && (cfg_c.side_rate != `MFCC_RATE_RES_HI);
    cfg_c.side_offset = st_q.side_rate_cfg[`MFCC_OFFS_LSB +: 4];
    cfg_c.gyro_decim = st_q.decim_cfg[`MFCC_GDEC_LSB +: 3];
    cfg_c.gyro_filtered = st_q.decim_cfg[`MFCC_GFILT_BIT];
    cfg_c.accel_decim = st_q.decim_cfg[`MFCC_ADEC_LSB +: 3];
    cfg_c.accel_filtered = st_q.decim_cfg[`MFCC_AFILT_BIT];
    cfg_c.threshold = thr_c;
    cfg_c.stop_on_full = st_q.behav_cfg[`MFCC_STOP_BIT];
    cfg_c.time_frame_en = st_q.behav_cfg[`MFCC_TIME_BIT];
    cfg_c.tag_select_first = st_q.content_cfg[`MFCC_TAG1_LSB +: 2];
    cfg_c.tag_select_second = st_q.content_cfg[`MFCC_TAG2_LSB +: 2];
    cfg_c.header_en = st_q.content_cfg[`MFCC_HDR_BIT];
    cfg_c.aux_store_en = st_q.content_cfg[`MFCC_AUXEN_BIT];
    cfg_c.accel_store_en = st_q.content_cfg[`MFCC_ACCEN_BIT];
    cfg_c.gyro_store_en = st_q.content_cfg[`MFCC_GYREN_BIT];
  end

  // threshold is low byte plus 256 times the high field
  assign thr_c = {st_q.thr_high[4:0], st_q.thr_low};
  assign wtm_c = (queue_fill >= thr_c);
  // Full when the fill reaches the storage size
  assign full_c = (32'(queue_fill) >= QUEUE_BYTES);

  // keep the first sample of each group
  assign gyro_keep_c = decim_keep(st_q.gyro_cnt, cfg_c.gyro_decim);
  assign accel_keep_c = decim_keep(st_q.accel_cnt, cfg_c.accel_decim);
  assign aux_keep_c = aux_sample && cfg_c.aux_store_en;

  // Edges use the second synchroniser stage only
  assign edge1_c = st_q.ev1_sync[1] && !st_q.ev1_prev;
  assign edge2_c = st_q.ev2_sync[1] && !st_q.ev2_prev;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic gyro_in;
    logic accel_in;
    logic any_in;
    logic blocked;
    logic [2:0] set_ev;
    st_d = st_q;
    gyro_in = 1'b0;
    accel_in = 1'b0;
    any_in = 1'b0;
    blocked = 1'b0;
    set_ev = 3'h0;

    // Pin synchronisers, two stages before use
    st_d.ev1_sync = {st_q.ev1_sync[0], event_pin_first};
    st_d.ev2_sync = {st_q.ev2_sync[0], event_pin_second};
    st_d.ev1_prev = st_q.ev1_sync[1];
    st_d.ev2_prev = st_q.ev2_sync[1];

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `MFCC_OFF_SIDE_RATE: st_d.side_rate_cfg = reg_wdata;
        `MFCC_OFF_DECIM: st_d.decim_cfg = reg_wdata;
        `MFCC_OFF_THR_LOW: st_d.thr_low = reg_wdata;
        // Only five bits exist above the low byte
        `MFCC_OFF_THR_HIGH: st_d.thr_high = {3'h0, reg_wdata[4:0]};
        `MFCC_OFF_BEHAV: st_d.behav_cfg = {6'h00, reg_wdata[1:0]};
        `MFCC_OFF_CONTENT: st_d.content_cfg = reg_wdata;
        `MFCC_OFF_IRQ_MASK: st_d.irq_mask = reg_wdata[2:0];
        default: ; // Unmapped writes are ignored
      endcase
    end

    // Register reads, data stands the next cycle only
    st_d.rd_data = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `MFCC_OFF_SIDE_RATE: st_d.rd_data = st_q.side_rate_cfg;
        `MFCC_OFF_DECIM: st_d.rd_data = st_q.decim_cfg;
        `MFCC_OFF_THR_LOW: st_d.rd_data = st_q.thr_low;
        `MFCC_OFF_THR_HIGH: st_d.rd_data = st_q.thr_high;
        `MFCC_OFF_BEHAV: st_d.rd_data = st_q.behav_cfg;
        `MFCC_OFF_CONTENT: st_d.rd_data = st_q.content_cfg;
        `MFCC_OFF_IRQ_STAT: st_d.rd_data = {5'h00, st_q.irq_stat};
        `MFCC_OFF_IRQ_MASK: st_d.rd_data = {5'h00, st_q.irq_mask};
        `MFCC_OFF_FILL_LOW: st_d.rd_data = queue_fill[7:0];
        `MFCC_OFF_FILL_HIGH: st_d.rd_data = {3'h0, queue_fill[12:8]};
        default: st_d.rd_data = 8'h00; // Unmapped reads return zero
      endcase
    end

    // gyro decimation counter advances on each arriving sample
    if (gyro_sample) begin
      st_d.gyro_cnt = decim_next(st_q.gyro_cnt, cfg_c.gyro_decim);
      gyro_in = gyro_keep_c && cfg_c.gyro_store_en;
    end
    if (accel_sample) begin
      st_d.accel_cnt = decim_next(st_q.accel_cnt, cfg_c.accel_decim);
      accel_in = accel_keep_c && cfg_c.accel_store_en;
    end
    // Decimation restarts when its factor is rewritten
    if (reg_wr && reg_addr == `MFCC_OFF_DECIM) begin
      st_d.gyro_cnt = 7'h00;
      st_d.accel_cnt = 7'h00;
    end

    any_in = gyro_in || accel_in || aux_keep_c;
    // refuse new samples into a full queue when stop_on_full is set
    blocked = cfg_c.stop_on_full && full_c;
    st_d.store = '0;
    if (any_in && !blocked) begin
      st_d.store.gyro_valid = gyro_in;
      st_d.store.accel_valid = accel_in;
      st_d.store.aux_valid = aux_keep_c;
      st_d.store.gyro_filtered = cfg_c.gyro_filtered;
      st_d.store.accel_filtered = cfg_c.accel_filtered;
      st_d.store.tag_first = tag_pick(cfg_c.tag_select_first, edge1_c, st_q.ev1_sync[1],
                                      accel_saturated, gyro_saturated);
      st_d.store.tag_second = tag_pick(cfg_c.tag_select_second, edge2_c, st_q.ev2_sync[1],
                                       accel_saturated, gyro_saturated);
      st_d.store.header_en = cfg_c.header_en;
    end

    // time frame follows the last data frame
    st_d.time_frame = queue_drained && cfg_c.time_frame_en;

    // readout offset delay, offset zero fires at once
    st_d.side_trig = 1'b0;
    if (st_q.delay_busy) begin
      if (st_q.delay_cnt != 32'h0) begin
        st_d.delay_cnt = st_q.delay_cnt - 32'h1;
      end else if (st_q.step_left != 4'h0) begin
        st_d.step_left = st_q.step_left - 4'h1;
        st_d.delay_cnt = STEP_CYCLES - 32'h1;
      end else begin
        st_d.delay_busy = 1'b0;
        st_d.side_trig = 1'b1;
      end
    end else if (side_tick && cfg_c.side_rate_ok) begin
      // reserved rates never trigger a readout
      if (cfg_c.side_offset == 4'h0) begin
        st_d.side_trig = 1'b1;
      end else begin
        st_d.delay_busy = 1'b1;
        st_d.step_left = cfg_c.side_offset - 4'h1;
        st_d.delay_cnt = STEP_CYCLES - 32'h1;
      end
    end

    // Watermark and full events on rising conditions; rate error on each reserved-rate tick
    st_d.wtm_seen = wtm_c;
    st_d.full_seen = full_c;
    set_ev[`MFCC_IRQ_WTM] = wtm_c && !st_q.wtm_seen;
    set_ev[`MFCC_IRQ_FULL] = full_c && !st_q.full_seen;
    set_ev[`MFCC_IRQ_RATE_ERR] = side_tick && !cfg_c.side_rate_ok;

    // Read clears status; a new event in the same cycle wins
    if (reg_rd && reg_addr == `MFCC_OFF_IRQ_STAT) begin
      st_d.irq_stat = set_ev;
    end else begin
      st_d.irq_stat = st_q.irq_stat | set_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.side_rate_cfg <= `MFCC_RST_SIDE_RATE;
      st_q.decim_cfg <= `MFCC_RST_DECIM;
      st_q.thr_low <= `MFCC_RST_THR_LOW;
      st_q.thr_high <= `MFCC_RST_THR_HIGH;
      st_q.behav_cfg <= `MFCC_RST_BEHAV;
      st_q.content_cfg <= `MFCC_RST_CONTENT;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = st_q.rd_data;
  assign cfg = cfg_c;
  assign store = st_q.store;
  // Any stored kind marks a frame
  assign store_valid = st_q.store.gyro_valid | st_q.store.accel_valid | st_q.store.aux_valid;
  assign side_trigger = st_q.side_trig;
  assign time_frame = st_q.time_frame;
  assign watermark = st_q.wtm_seen;
  assign irq = |(st_q.irq_stat & st_q.irq_mask);

endmodule // mfcc_top

// ---- tb/mfcc_top_checker.sv ----
/*
  Port checker for the queue content configuration block.
  Assumes it is bound onto mfcc_top and shares its single clock.
*/
`timescale 1ns/10ps
module mfcc_top_checker
  import mfcc_pkg::*;
#(
  parameter int unsigned QUEUE_BYTES = 2048
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic gyro_sample,
  input wire logic accel_sample,
  input wire logic aux_sample,
  input wire logic [12:0] queue_fill,
  input wire logic queue_drained,
  input wire mfcc_cfg_type cfg,
  input wire mfcc_store_type store,
  input wire logic store_valid,
  input wire logic time_frame,
  input wire logic watermark
);
  // One domain, so one clock and one reset for every property
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_rate_ok; cfg.side_rate_ok == (cfg.side_rate != 4'h0 && cfg.side_rate != 4'hf); endproperty
  a_rate_ok: assert property (p_rate_ok) else $error("rate code check wrong");
  // Level lags the fill by one cycle, so compare with last cycle's inputs
  property p_wtm; watermark == ($past(queue_fill) >= $past(cfg.threshold)); endproperty
  a_wtm: assert property (p_wtm) else $error("watermark level wrong");
  property p_full; cfg.stop_on_full && queue_fill >= QUEUE_BYTES |=> !store_valid; endproperty
  a_full: assert property (p_full) else $error("store into full queue");
  property p_time; queue_drained |=> time_frame == $past(cfg.time_frame_en); endproperty
  a_time: assert property (p_time) else $error("time frame wrong");
  property p_hdr; store_valid |-> store.header_en == $past(cfg.header_en); endproperty
  a_hdr: assert property (p_hdr) else $error("header flag wrong");
  property p_aux; store.aux_valid |-> $past(aux_sample && cfg.aux_store_en); endproperty
  a_aux: assert property (p_aux) else $error("aux stored while off");
  property p_acc; store.accel_valid |-> $past(accel_sample && cfg.accel_store_en); endproperty
  a_acc: assert property (p_acc) else $error("accel stored while off");
  property p_gyr; store.gyro_valid |-> $past(gyro_sample && cfg.gyro_store_en); endproperty
  a_gyr: assert property (p_gyr) else $error("gyro stored while off");
endmodule // mfcc_top_checker

bind mfcc_top mfcc_top_checker #(.QUEUE_BYTES(QUEUE_BYTES)) i_mfcc_top_checker (.*);

// ---- tb/mfcc_host_model.sv ----
/*
  Host side of the queue: counts stored bytes and drains on request.
  Assumes the block's clock; the bench commands loads and drains.
*/
`timescale 1ns/10ps
module mfcc_host_model #(
  parameter int unsigned FRAME_BYTES = 7
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic store_valid,
  input wire logic load,
  input wire logic [12:0] load_val,
  input wire logic drain,
  output logic [12:0] queue_fill,
  output logic queue_drained
);
  // Fill clears at once on reset so the block never sees a stale level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_fill <= 13'h0000;
      queue_drained <= 1'b0;
    end else begin
      queue_drained <= drain;
      if (drain) begin
        queue_fill <= 13'h0000;
      end else if (load) begin
        queue_fill <= load_val;
      end else if (store_valid) begin
        queue_fill <= queue_fill + 13'(FRAME_BYTES);
      end
    end
  end
endmodule // mfcc_host_model

// ---- tb/mfcc_top_tb.sv ----
/*
  Self-checking bench for the queue content configuration block.
  Assumes a step count shortened to 4 cycles and the host queue model.
*/
`timescale 1ns/10ps
module mfcc_top_tb
  import mfcc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, gyro_sample = 1'b0, accel_sample = 1'b0, aux_sample = 1'b0;
  logic side_tick = 1'b0, accel_saturated = 1'b0, gyro_saturated = 1'b0;
  logic event_pin_first = 1'b0, event_pin_second = 1'b0, load = 1'b0, drain = 1'b0;
  logic [12:0] load_val = 13'h0000, queue_fill;
  logic queue_drained, store_valid, side_trigger, time_frame, watermark, irq;
  mfcc_cfg_type cfg;
  mfcc_store_type store;
  int errors = 0, checks = 0, gcnt = 0, acnt = 0, xcnt = 0, k;
  // Rows: address, written value, value read back
  logic [23:0] rows [6] = '{24'h441515, 24'h47ff1f, 24'h48ff03, 24'h50ff00, 24'h605a00, 24'h46a5a5};
  logic [7:0] rv [6] = '{8'h46, 8'h88, 8'h00, 8'h02, 8'h02, 8'h10};

  always #50 ref_clk = ~ref_clk;

  mfcc_top #(.STEP_CYCLES(4), .QUEUE_BYTES(2048)) i_mfcc_top (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .gyro_sample, .accel_sample, .aux_sample, .side_tick, .accel_saturated,
    .gyro_saturated, .event_pin_first, .event_pin_second, .queue_fill, .queue_drained, .cfg, .store,
    .store_valid, .side_trigger, .time_frame, .watermark, .irq);
  mfcc_host_model i_mfcc_host_model (.ref_clk, .rst_n, .store_valid, .load, .load_val, .drain,
    .queue_fill, .queue_drained);

  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  // One sample pulse; stores are counted in the cycle they stand
  task automatic smp(input logic g, input logic a, input logic x);
    @(posedge ref_clk);
    gyro_sample <= g;
    accel_sample <= a;
    aux_sample <= x;
    @(posedge ref_clk);
    gyro_sample <= 1'b0;
    accel_sample <= 1'b0;
    aux_sample <= 1'b0;
    #1;
    gcnt += int'(store.gyro_valid === 1'b1);
    acnt += int'(store.accel_valid === 1'b1);
    xcnt += int'(store.aux_valid === 1'b1);
  endtask
  task automatic trig(input logic [7:0] e);
    @(posedge ref_clk);
    side_tick <= 1'b1;
    @(posedge ref_clk);
    side_tick <= 1'b0;
    #1 k = 1;
    while (side_trigger !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1 k++;
    end
    chk("side_trigger delay", {8'h00, e}, 16'(k));
  endtask
  task automatic setfill(input logic [12:0] v);
    @(posedge ref_clk);
    load <= 1'b1;
    load_val <= v;
    @(posedge ref_clk);
    load <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic dr(input logic e);
    @(posedge ref_clk);
    drain <= 1'b1;
    @(posedge ref_clk);
    drain <= 1'b0;
    @(posedge ref_clk);
    #1 chk("time_frame", {15'h0, e}, {15'h0, time_frame});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'h44 + 8'(i), rv[i]);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    $display("test registers finished");
    wr(8'h44, 8'h16);
    trig(8'h05);
    wr(8'h44, 8'h06);
    trig(8'h01);
    wr(8'h44, 8'h10);
    trig(8'h28);
    wr(8'h44, 8'h1f);
    trig(8'h28);
    rd(8'h50, 8'h04);
    $display("test side trigger finished");
    wr(8'h49, 8'hc0);
    wr(8'h48, 8'h02);
    wr(8'h45, 8'h21);
    for (int i = 0; i < 8; i++) begin
      smp(1'b1, 1'b1, 1'b1);
      if (i == 0) chk("first kept", 16'h0003, {14'h0, store.accel_valid, store.gyro_valid});
      if (i == 0) chk("filter sel", 16'h0000, {14'h0, store.accel_filtered, store.gyro_filtered});
    end
    chk("decimated", 16'h0042, {8'h00, 4'(gcnt), 4'(acnt)});
    wr(8'h49, 8'h20);
    smp(1'b1, 1'b1, 1'b1);
    chk("store enables", 16'h0142, {4'h0, 4'(xcnt), 4'(gcnt), 4'(acnt)});
    $display("test decimation finished");
    // Each row makes one tag source active; only its code may tag
    // Decimation off, so every gyro sample is stored and carries tags
    wr(8'h45, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      event_pin_first <= (i == 0);
      event_pin_second <= (i == 0);
      accel_saturated <= (i == 1);
      gyro_saturated <= (i == 2);
      repeat (4) @(posedge ref_clk);
      for (int c = 0; c < 4; c++) begin
        wr(8'h49, 8'h90 + 8'(c * 5));
        smp(1'b1, 1'b0, 1'b0);
        chk("tags", (c == i + 1) ? 16'h0003 : 16'h0000, {14'h0, store.tag_first, store.tag_second});
      end
    end
    // Edge code: the sample must land in the one cycle the synchronised edge stands
    wr(8'h49, 8'h90);
    @(posedge ref_clk);
    event_pin_first <= 1'b1;
    event_pin_second <= 1'b1;
    @(posedge ref_clk);
    smp(1'b1, 1'b0, 1'b0);
    chk("edge tags", 16'h0003, {14'h0, store.tag_first, store.tag_second});
    $display("test tags finished");
    wr(8'h46, 8'h10);
    wr(8'h47, 8'h01);
    wr(8'h51, 8'h01);
    setfill(13'd271);
    chk("below mark", 16'h0000, {14'h0, watermark, irq});
    setfill(13'd272);
    chk("at mark", 16'h0003, {14'h0, watermark, irq});
    rd(8'h50, 8'h01);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    $display("test watermark finished");
    wr(8'h45, 8'h00);
    wr(8'h48, 8'h01);
    setfill(13'd2048);
    k = gcnt;
    smp(1'b1, 1'b0, 1'b0);
    wr(8'h48, 8'h00);
    smp(1'b1, 1'b0, 1'b0);
    chk("stop on full", 16'(k + 1), 16'(gcnt));
    wr(8'h48, 8'h02);
    dr(1'b1);
    wr(8'h48, 8'h00);
    dr(1'b0);
    $display("test queue end finished");
    // Reset in mid-run must bring the content register back
    wr(8'h49, 8'h55);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h49, 8'h10);
    $display("test second reset finished");
    results();
  end

  // A hang counts as a mismatch
  initial begin
    #5000000;
    errors++;
    results();
  end
endmodule // mfcc_top_tb
